//--- design/acc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// RULE_01 - Alignment bit re-presents result bytes immediately
// RULE_02 - Selection changes apply only after completion
// RULE_03 - Codes 0-7 single-ended, 30 bandgap, 31 ground
// RULE_04 - Codes 8-15 differential, gain 10x/200x
// RULE_05 - Codes 16-29 differential at unity gain
// RULE_06 - Clearing converter on aborts running conversion
// RULE_07 - Software writes go to start conversions
// RULE_08 - First conversion 25 cycles, later 13
// RULE_09 - Go reads one while busy; zero ignored
// RULE_10 - Auto trigger starts on rising source edge
// RULE_11 - Done flag set when result updated
// RULE_12 - Done flag cleared by vector or one
// RULE_13 - Interrupt when flag, enable, global enable
// RULE_14 - Divider field sets converter clock rate
// RULE_15 - Low byte read locks result until high
// RULE_16 - Software reads low byte before high
// RULE_17 - Differential results kept as two's complement
// RULE_18 - Right aligned: low byte holds bits 7:0
// RULE_19 - Right aligned: high byte holds bits 9:8
// RULE_20 - Left aligned: high 9:2, low 1:0 at top
// RULE_21 - Trigger source field, ignored without auto trigger
// RULE_22 - Source switch may trigger; free running never
// RULE_23 - Free running restarts on each completion
module acc_conversion_control (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    // I/O register port
    input  wire logic [5:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    // Trigger flags, bit n for source code n, bit 0 unused
    input  wire logic [7:0] trigger_flags_i,
    // Interrupt
    input  wire logic       global_irq_on_i,
    input  wire logic       irq_ack_i,
    output logic            irq_o,
    // Converter core
    input  wire logic [9:0] core_data_i,
    output logic            converter_on_o,
    output logic            conv_active_o,
    output logic            conv_init_o,
    output logic            conv_tick_o,
    output logic            conv_done_o,
    // Input multiplexer and gain stage
    output logic      [2:0] pos_input_o,
    output logic      [1:0] neg_input_o,
    output logic      [1:0] gain_o,
    output logic            differential_o,
    output logic            bandgap_o,
    output logic            ground_o,
    output logic      [1:0] ref_select_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decode functions

    // Routing word: {diff, bandgap, ground, gain[1:0], neg[1:0], pos[2:0]}
    function automatic logic [9:0] route_of(input logic [4:0] sel);
        logic [9:0] r;
        r = 10'h000;
        case (sel[4:3])
            2'b00:   r = {1'b0, 1'b0, 1'b0, acc_pkg::GAIN_1X, 2'h0, sel[2:0]}; // [RULE_03]
            2'b01:   r = {1'b1, 1'b0, 1'b0,
                          sel[1] ? acc_pkg::GAIN_200X : acc_pkg::GAIN_10X,
                          sel[2] ? 2'h2 : 2'h0,
                          {1'b0, sel[2], sel[0]}};                           // [RULE_04]
            2'b10:   r = {1'b1, 1'b0, 1'b0, acc_pkg::GAIN_1X, 2'h1, sel[2:0]}; // [RULE_05]
            default:
            begin
                if (sel == acc_pkg::SEL_BANDGAP)
                    r = {1'b0, 1'b1, 1'b0, acc_pkg::GAIN_1X, 2'h0, 3'h0};      // [RULE_03]
                else if (sel == acc_pkg::SEL_GROUND)
                    r = {1'b0, 1'b0, 1'b1, acc_pkg::GAIN_1X, 2'h0, 3'h0};      // [RULE_03]
                else
                    r = {1'b1, 1'b0, 1'b0, acc_pkg::GAIN_1X, 2'h2, sel[2:0]}; // [RULE_05]
            end
        endcase
        return r;
    endfunction : route_of

    // Prescaler mask: division factor minus one
    function automatic logic [6:0] div_mask(input logic [2:0] ps);
        logic [6:0] m;
        m = 7'h01;
        case (ps)
            3'h0, 3'h1: m = 7'h01;
            3'h2:       m = 7'h03;
            3'h3:       m = 7'h07;
            3'h4:       m = 7'h0F;
            3'h5:       m = 7'h1F;
            3'h6:       m = 7'h3F;
            default:    m = 7'h7F;
        endcase
        return m;
    endfunction : div_mask

    ////////////////////////////////////////////////////////////////////////////////
    // State

    acc_pkg::acc_state_t state_reg, state_next;
    logic       on_reg, on_next;
    logic       go_reg, go_next;
    logic       ate_reg, ate_next;
    logic       flag_reg, flag_next;
    logic       ie_reg, ie_next;
    logic [2:0] ps_reg, ps_next;
    logic [7:0] sel_reg, sel_next;
    logic [2:0] ts_reg, ts_next;
    logic [9:0] result_reg, result_next;
    logic       lock_reg, lock_next;
    logic       first_reg, first_next;
    logic [4:0] len_reg, len_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [6:0] presc_reg, presc_next;
    logic       trig_prev_reg, trig_prev_next;
    logic [4:0] cur_sel_reg, cur_sel_next;
    logic [1:0] cur_ref_reg, cur_ref_next;
    logic [9:0] route_reg, route_next;
    logic [7:0] rdata_reg, rdata_next;

    logic wr_ctrl;
    logic tick;
    logic trig_rise;
    logic sw_start;
    logic auto_start;
    logic free_start;
    logic start;
    logic done;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        wr_ctrl    = io_wr_i && (io_addr_i == acc_pkg::CTRL_STATUS_OFS);
        // Masked compare keeps every divider exact off one free counter
        tick       = on_reg && ((presc_reg & div_mask(ps_reg)) == div_mask(ps_reg)); // [RULE_14]
        trig_rise  = trigger_flags_i[ts_reg] && !trig_prev_reg;                      // [RULE_22]
        done       = (state_reg == acc_pkg::ACC_CONV) && tick
                     && (cnt_reg == len_reg - 5'd1);

        on_next    = wr_ctrl ? io_wdata_i[acc_pkg::CONVERTER_ON_BIT] : on_reg;
        // Writing zero to go leaves it alone
        sw_start   = wr_ctrl && io_wdata_i[acc_pkg::CONVERSION_GO_BIT];         // [RULE_09]
        auto_start = ate_reg && (ts_reg != acc_pkg::FREE_RUNNING) && trig_rise; // [RULE_10] [RULE_21]
        free_start = done && ate_reg && (ts_reg == acc_pkg::FREE_RUNNING);      // [RULE_23]
        start      = on_next && (free_start
                     || ((state_reg == acc_pkg::ACC_IDLE) && (sw_start || auto_start)));

        ate_next   = wr_ctrl ? io_wdata_i[acc_pkg::AUTO_TRIGGER_BIT] : ate_reg;
        ie_next    = wr_ctrl ? io_wdata_i[acc_pkg::DONE_IRQ_ON_BIT] : ie_reg;
        ps_next    = wr_ctrl ? io_wdata_i[acc_pkg::DIVIDER_MSB:0] : ps_reg;
        sel_next   = (io_wr_i && io_addr_i == acc_pkg::INPUT_SEL_OFS) ? io_wdata_i : sel_reg;
        ts_next    = (io_wr_i && io_addr_i == acc_pkg::SPECIAL_FUNC_OFS)
                     ? io_wdata_i[7:acc_pkg::TRIGGER_SEL_LSB] : ts_reg;
        trig_prev_next = trigger_flags_i[ts_reg];

        // Set beats clear so a completion in the clear cycle is kept
        flag_next  = flag_reg;
        if ((wr_ctrl && io_wdata_i[acc_pkg::DONE_FLAG_BIT]) || irq_ack_i)
            flag_next = 1'b0;                                                // [RULE_12]
        if (done)
            flag_next = 1'b1;                                                // [RULE_11]

        state_next = state_reg;
        go_next    = go_reg;
        cnt_next   = cnt_reg;
        len_next   = len_reg;
        if (!on_next)
        begin
            state_next = acc_pkg::ACC_IDLE;                                  // [RULE_06]
            go_next    = 1'b0;
            cnt_next   = 5'd0;
        end
        else if (start)
        begin
            state_next = acc_pkg::ACC_CONV;
            go_next    = 1'b1;                                               // [RULE_09]
            cnt_next   = 5'd0;
            len_next   = first_reg ? acc_pkg::FIRST_CONV_CYCLES
                                   : acc_pkg::NORMAL_CONV_CYCLES;            // [RULE_08]
        end
        else if (done)
        begin
            state_next = acc_pkg::ACC_IDLE;
            go_next    = 1'b0;                                               // [RULE_09]
        end
        else if ((state_reg == acc_pkg::ACC_CONV) && tick)
            cnt_next = cnt_reg + 5'd1;

        first_next = !on_next ? 1'b1 : (start ? 1'b0 : first_reg);           // [RULE_08]
        presc_next = on_reg ? presc_reg + 7'd1 : 7'd0;

        // Core delivers two's complement for differential pairs; stored as is
        result_next = (done && !lock_reg) ? core_data_i : result_reg;        // [RULE_15] [RULE_17]
        lock_next   = lock_reg;
        if (io_rd_i && io_addr_i == acc_pkg::RESULT_HIGH_OFS)
            lock_next = 1'b0;                                                // [RULE_15]
        else if (io_rd_i && io_addr_i == acc_pkg::RESULT_LOW_OFS)
            lock_next = 1'b1;                                                // [RULE_15]

        // Routing only follows the register between conversions
        if ((state_reg == acc_pkg::ACC_IDLE) || done)
        begin
            cur_sel_next = sel_reg[acc_pkg::GAIN_SELECT_MSB:0];              // [RULE_02]
            cur_ref_next = sel_reg[7:acc_pkg::REF_SELECT_LSB];
        end
        else
        begin
            cur_sel_next = cur_sel_reg;
            cur_ref_next = cur_ref_reg;
        end
        route_next = route_of(cur_sel_next);

        // Alignment applied at read time, so a change shows at once
        rdata_next = 8'h00;
        if (io_rd_i)
        begin
            case (io_addr_i)
                acc_pkg::RESULT_LOW_OFS:
                    rdata_next = sel_reg[acc_pkg::LEFT_ALIGN_BIT]
                                 ? {result_reg[1:0], 6'h00}                  // [RULE_01] [RULE_20]
                                 : result_reg[7:0];                          // [RULE_18]
                acc_pkg::RESULT_HIGH_OFS:
                    rdata_next = sel_reg[acc_pkg::LEFT_ALIGN_BIT]
                                 ? result_reg[9:2]                           // [RULE_20]
                                 : {6'h00, result_reg[9:8]};                 // [RULE_19]
                acc_pkg::CTRL_STATUS_OFS:
                    rdata_next = {on_reg, go_reg, ate_reg, flag_reg, ie_reg, ps_reg};
                acc_pkg::INPUT_SEL_OFS:
                    rdata_next = sel_reg;
                acc_pkg::SPECIAL_FUNC_OFS:
                    rdata_next = {ts_reg, 5'h00};
                default:
                    rdata_next = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            state_reg     <= acc_pkg::ACC_IDLE;
            on_reg        <= acc_pkg::CTRL_STATUS_RST[acc_pkg::CONVERTER_ON_BIT];
            go_reg        <= acc_pkg::CTRL_STATUS_RST[acc_pkg::CONVERSION_GO_BIT];
            ate_reg       <= acc_pkg::CTRL_STATUS_RST[acc_pkg::AUTO_TRIGGER_BIT];
            flag_reg      <= acc_pkg::CTRL_STATUS_RST[acc_pkg::DONE_FLAG_BIT];
            ie_reg        <= acc_pkg::CTRL_STATUS_RST[acc_pkg::DONE_IRQ_ON_BIT];
            ps_reg        <= acc_pkg::CTRL_STATUS_RST[acc_pkg::DIVIDER_MSB:0];
            sel_reg       <= acc_pkg::INPUT_SEL_RST;
            ts_reg        <= acc_pkg::TRIGGER_SEL_RST;
            result_reg    <= acc_pkg::RESULT_RST;
            lock_reg      <= 1'b0;
            first_reg     <= 1'b1;
            len_reg       <= acc_pkg::NORMAL_CONV_CYCLES;
            cnt_reg       <= 5'd0;
            presc_reg     <= 7'd0;
            trig_prev_reg <= 1'b0;
            cur_sel_reg   <= 5'h00;
            cur_ref_reg   <= 2'h0;
            route_reg     <= 10'h000;
            rdata_reg     <= 8'h00;
        end
        else
        begin
            state_reg     <= state_next;
            on_reg        <= on_next;
            go_reg        <= go_next;
            ate_reg       <= ate_next;
            flag_reg      <= flag_next;
            ie_reg        <= ie_next;
            ps_reg        <= ps_next;
            sel_reg       <= sel_next;
            ts_reg        <= ts_next;
            result_reg    <= result_next;
            lock_reg      <= lock_next;
            first_reg     <= first_next;
            len_reg       <= len_next;
            cnt_reg       <= cnt_next;
            presc_reg     <= presc_next;
            trig_prev_reg <= trig_prev_next;
            cur_sel_reg   <= cur_sel_next;
            cur_ref_reg   <= cur_ref_next;
            route_reg     <= route_next;
            rdata_reg     <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign io_rdata_o     = rdata_reg;
    assign irq_o          = flag_reg && ie_reg && global_irq_on_i;           // [RULE_13]
    assign converter_on_o = on_reg;
    assign conv_active_o  = (state_reg == acc_pkg::ACC_CONV);
    assign conv_init_o    = (state_reg == acc_pkg::ACC_CONV)
                            && (len_reg == acc_pkg::FIRST_CONV_CYCLES);
    assign conv_tick_o    = tick;
    assign conv_done_o    = done;
    assign pos_input_o    = route_reg[2:0];
    assign neg_input_o    = route_reg[4:3];
    assign gain_o         = route_reg[6:5];
    assign ground_o       = route_reg[7];
    assign bandgap_o      = route_reg[8];
    assign differential_o = route_reg[9];
    assign ref_select_o   = cur_ref_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (srst_i);

    // Divider and enable left alone over the window being judged
    sequence div4_hold_s;
        (on_reg && !wr_ctrl) [*3];
    endsequence

    go_while_busy_a: assert property (                                      // [RULE_09]
        conv_active_o |-> go_reg) else $error("go bit low during conversion");

    abort_on_off_a: assert property (                                       // [RULE_06]
        (wr_ctrl && !io_wdata_i[acc_pkg::CONVERTER_ON_BIT]) |=> !conv_active_o && !go_reg)
        else $error("conversion not aborted");

    first_length_a: assert property (                                       // [RULE_08]
        (start && first_reg) |=> len_reg == 5'd25) else $error("first length wrong");

    later_length_a: assert property (                                       // [RULE_08]
        (start && !first_reg) |=> len_reg == 5'd13) else $error("later length wrong");

    flag_on_done_a: assert property (                                       // [RULE_11]
        done |=> flag_reg) else $error("done flag not set");

    flag_zero_write_a: assert property (                                    // [RULE_12]
        (flag_reg && wr_ctrl && !io_wdata_i[acc_pkg::DONE_FLAG_BIT] && !irq_ack_i)
        |=> flag_reg) else $error("zero write cleared flag");

    irq_raise_a: assert property (                                          // [RULE_13]
        (flag_reg && ie_reg && global_irq_on_i) |-> irq_o) else $error("irq missing");

    lock_hold_a: assert property (                                          // [RULE_15]
        (lock_reg && !io_rd_i) |=> $stable(result_reg)) else $error("locked result moved");

    sel_hold_a: assert property (                                           // [RULE_02]
        (conv_active_o && !done) |=> $stable(cur_sel_reg)) else $error("selection moved");

    div4_period_a: assert property (                                        // [RULE_14]
        (tick && ps_reg == 3'h2 && on_reg) ##1 (ps_reg == 3'h2 && on_reg && !wr_ctrl) [*3]
        |=> tick) else $error("divide by four broken");

    div4_gap_a: assert property (                                           // [RULE_14]
        (tick && ps_reg == 3'h2 && on_reg && !wr_ctrl) ##1 div4_hold_s
        |-> (!tick && !$past(tick) && !$past(tick, 2)) ##1 tick)
        else $error("divide by four gap broken");

    free_restart_a: assert property (                                       // [RULE_23]
        (done && ate_reg && ts_reg == acc_pkg::FREE_RUNNING && on_next)
        |=> conv_active_o) else $error("free running did not restart");

    high_right_a: assert property (                                         // [RULE_19]
        (io_rd_i && io_addr_i == acc_pkg::RESULT_HIGH_OFS && !sel_reg[5])
        |=> io_rdata_o[7:2] == 6'h00) else $error("high byte upper bits set");

endmodule : acc_conversion_control

`default_nettype wire

//--- common/acc_pkg.sv
package acc_pkg;

    // I/O register offsets
    localparam logic [5:0] RESULT_LOW_OFS   = 6'h04;
    localparam logic [5:0] RESULT_HIGH_OFS  = 6'h05;
    localparam logic [5:0] CTRL_STATUS_OFS  = 6'h06;
    localparam logic [5:0] INPUT_SEL_OFS    = 6'h07;
    localparam logic [5:0] SPECIAL_FUNC_OFS = 6'h30;

    // Control/status field positions
    localparam int CONVERTER_ON_BIT  = 7;
    localparam int CONVERSION_GO_BIT = 6;
    localparam int AUTO_TRIGGER_BIT  = 5;
    localparam int DONE_FLAG_BIT     = 4;
    localparam int DONE_IRQ_ON_BIT   = 3;
    localparam int DIVIDER_MSB       = 2;

    // Input select field positions
    localparam int REF_SELECT_LSB    = 6;
    localparam int LEFT_ALIGN_BIT    = 5;
    localparam int GAIN_SELECT_MSB   = 4;

    // Trigger source field position
    localparam int TRIGGER_SEL_LSB   = 5;

    // Reset values
    localparam logic [7:0] CTRL_STATUS_RST  = 8'h00;
    localparam logic [7:0] INPUT_SEL_RST    = 8'h00;
    localparam logic [2:0] TRIGGER_SEL_RST  = 3'h0;
    localparam logic [9:0] RESULT_RST       = 10'h000;

    // Conversion lengths in converter clock cycles
    localparam logic [4:0] FIRST_CONV_CYCLES  = 5'd25;
    localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;

    // Trigger source code for free running
    localparam logic [2:0] FREE_RUNNING = 3'h0;

    // Gain codes to the gain stage
    localparam logic [1:0] GAIN_1X   = 2'h0;
    localparam logic [1:0] GAIN_10X  = 2'h1;
    localparam logic [1:0] GAIN_200X = 2'h2;

    // Selection codes with a special single-ended source
    localparam logic [4:0] SEL_BANDGAP = 5'h1E;
    localparam logic [4:0] SEL_GROUND  = 5'h1F;

    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_CONV = 1'b1
    } acc_state_t;

endpackage : acc_pkg

//--- dv/acc_core_model.sv
`timescale 1ns/1ps
`default_nettype none

// Stand-in for the converter core: the result echoes the routing it was given
module acc_core_model (
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    // From the control block
    input  wire logic       active_i,
    input  wire logic       tick_i,
    input  wire logic       done_i,
    input  wire logic [9:0] route_i,
    // To the control block and bench
    output logic      [9:0] data_o,
    output logic      [9:0] last_o,
    output logic      [5:0] ticks_o,
    output logic      [7:0] gap_o,
    output logic      [7:0] dones_o
);
    logic [5:0] tick_cnt;
    logic [7:0] gap_cnt;

    // Inverted outside conversions so a stale sample shows
    assign data_o = active_i ? route_i : ~route_i;

    always_ff @(posedge clock_i)
    begin
        gap_cnt <= tick_i ? 8'h00 : gap_cnt + 8'h01;
        if (tick_i)
            gap_o <= gap_cnt + 8'h01;
        tick_cnt <= (srst_i || !active_i || done_i) ? 6'h00 : tick_cnt + 6'(tick_i);
        if (done_i)
        begin
            last_o  <= data_o;
            ticks_o <= tick_cnt + 6'h01;
        end
        dones_o <= srst_i ? 8'h00 : dones_o + 8'(done_i);
    end
endmodule : acc_core_model

`default_nettype wire

//--- dv/acc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module acc_conversion_control_tb;
    localparam logic [5:0] LO  = acc_pkg::RESULT_LOW_OFS;
    localparam logic [5:0] HI  = acc_pkg::RESULT_HIGH_OFS;
    localparam logic [5:0] CS  = acc_pkg::CTRL_STATUS_OFS;
    localparam logic [5:0] SEL = acc_pkg::INPUT_SEL_OFS;
    localparam logic [5:0] TS  = acc_pkg::SPECIAL_FUNC_OFS;
    localparam logic [5:0] OFS [6] = '{LO, HI, CS, SEL, TS, 6'h3F};

    logic       clock_i, srst_i, io_wr_i, io_rd_i, global_irq_on_i, irq_ack_i;
    logic       irq_o, conv_active_o, conv_tick_o, conv_done_o;
    logic       differential_o, bandgap_o, ground_o, first;
    logic       converter_on_o, conv_init_o;
    logic [5:0] io_addr_i, last_ticks;
    logic [7:0] io_wdata_i, io_rdata_o, trigger_flags_i, tick_gap, dones;
    logic [2:0] pos_input_o;
    logic [1:0] neg_input_o, gain_o;
    logic [9:0] core_data_i, last_data;
    int         miscompares, tests_run;

    acc_conversion_control DUT (
        .clock_i, .srst_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i, .io_rdata_o,
        .trigger_flags_i, .global_irq_on_i, .irq_ack_i, .irq_o, .core_data_i,
        .converter_on_o, .conv_active_o, .conv_init_o, .conv_tick_o, .conv_done_o,
        .pos_input_o, .neg_input_o, .gain_o, .differential_o, .bandgap_o, .ground_o,
        .ref_select_o ()
    );

    acc_core_model core (
        .clock_i, .srst_i, .active_i (conv_active_o), .tick_i (conv_tick_o),
        .done_i (conv_done_o), .data_o (core_data_i), .last_o (last_data),
        .ticks_o (last_ticks), .gap_o (tick_gap), .dones_o (dones),
        .route_i ({differential_o, gain_o, neg_input_o, pos_input_o, bandgap_o, ground_o})
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Expected routing as {mask, value}; unconnected fields are masked out
    function automatic logic [19:0] exp_route(input logic [4:0] s);
        if (s < 5'h08)
            return {10'h21F, 5'h00, s[2:0], 2'b00};
        if (s < 5'h10)
            return {10'h3FF, 1'b1, s[1] ? acc_pkg::GAIN_200X : acc_pkg::GAIN_10X,
                    s[2] ? 2'd2 : 2'd0, 1'b0, s[2], s[0], 2'b00};
        if (s < acc_pkg::SEL_BANDGAP)
            return {10'h3FF, 1'b1, acc_pkg::GAIN_1X, s[3] ? 2'd2 : 2'd1, s[2:0], 2'b00};
        return {10'h203, 8'h00, s == acc_pkg::SEL_BANDGAP, s == acc_pkg::SEL_GROUND};
    endfunction : exp_route

    function automatic logic [15:0] present(input logic [9:0] r, input logic left);
        return left ? {r, 6'h00} : {6'h00, r};
    endfunction : present

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clock_i);
        io_addr_i  <= a;
        io_wdata_i <= d;
        io_wr_i    <= 1'b1;
        @(posedge clock_i);
        io_wr_i <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clock_i);
        io_addr_i <= a;
        io_rd_i   <= 1'b1;
        @(posedge clock_i);
        io_rd_i <= 1'b0;
        #1;
        d = io_rdata_o;
    endtask : rd

    task automatic wait_idle();
        int i;
        repeat (3) @(posedge clock_i);
        for (i = 0; i < 20000; i++)
        begin
            @(posedge clock_i);
            #1;
            if (conv_active_o === 1'b0)
                break;
        end
        if (i == 20000)
        begin
            miscompares++;
            final_report();
        end
    endtask : wait_idle

    // One conversion; the selection is changed to nxt while it runs
    task automatic conv(input logic [4:0] s, input logic [4:0] nxt, input logic [2:0] dv,
                        input logic left);
        logic [7:0]  lo, hi;
        logic [19:0] er;
        wr(SEL, {2'b00, left, s});
        trigger_flags_i <= 8'($urandom);
        wr(CS, {5'b11010, dv});
        rd(CS, lo);
        `CHK("busy status", {5'b11000, dv}, lo)
        `CHK("init flag", first, conv_init_o)
        wr(SEL, {2'b00, left, nxt});
        wait_idle();
        rd(CS, lo);
        `CHK("done status", {5'b10010, dv}, lo)
        `CHK("conversion ticks", first ? 6'd25 : 6'd13, last_ticks)
        `CHK("tick spacing", (dv < 3'h2) ? 8'h02 : (8'h01 << dv), tick_gap)
        first = 1'b0;
        er = exp_route(s);
        `CHK("routing", er[9:0], last_data & er[19:10])
        rd(LO, lo);
        rd(HI, hi);
        `CHK("result bytes", present(last_data, left), {hi, lo})
        wr(SEL, {2'b00, ~left, nxt});
        rd(LO, lo);
        rd(HI, hi);
        `CHK("realigned bytes", present(last_data, ~left), {hi, lo})
    endtask : conv

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    initial
    begin
        int         k;
        logic [7:0] v, d0;
        logic [9:0] saved;
        {io_wr_i, io_rd_i, global_irq_on_i, irq_ack_i} = 4'h0;
        {io_addr_i, io_wdata_i, trigger_flags_i} = 22'h0;
        srst_i = 1'b1;
        void'($urandom(32'h1b5b));
        repeat (6) @(posedge clock_i);
        srst_i <= 1'b0;
        for (k = 0; k < 6; k++)
        begin
            rd(OFS[k], v);
            `CHK("reset value", 8'h00, v)
        end
        first = 1'b1;
        for (k = 0; k < 32; k++)
            conv(5'(k), 5'(k + 1), 3'(k), 1'($urandom));
        for (k = 0; k < 4; k++)
        begin
            wr(CS, {4'b1000, k[0], 3'h1});
            global_irq_on_i <= k[1];
            @(posedge clock_i);
            #1;
            `CHK("irq request", k[0] & k[1], irq_o)
        end
        @(posedge clock_i);
        irq_ack_i <= 1'b1;
        @(posedge clock_i);
        irq_ack_i <= 1'b0;
        rd(CS, v);
        `CHK("flag after vector", 8'h89, v)
        // Low byte read must hold off the next result
        conv(5'h10, 5'h11, 3'h1, 1'b1);
        saved = last_data;
        rd(LO, v);
        wr(CS, 8'hD9);
        wait_idle();
        rd(HI, v);
        `CHK("locked high byte", {6'h00, saved[9:8]}, v)
        rd(LO, v);
        `CHK("locked low byte", saved[7:0], v)
        rd(HI, v);
        wr(CS, 8'hD1);
        wr(CS, 8'h01);
        @(posedge clock_i);
        #1;
        `CHK("aborted", 1'b0, conv_active_o)
        `CHK("converter off", 1'b0, converter_on_o)
        rd(CS, v);
        `CHK("status after abort", 8'h01, v)
        first = 1'b1;
        conv(5'h1E, 5'h1F, 3'h0, 1'b0);
        wr(TS, 8'h40);
        trigger_flags_i <= 8'h00;
        wr(CS, 8'hB1);
        wait_idle();
        `CHK("no start without edge", 1'b0, conv_active_o)
        trigger_flags_i <= 8'h04;
        wait_idle();
        rd(CS, v);
        `CHK("triggered status", 8'hB1, v)
        wr(CS, 8'hB1);
        trigger_flags_i <= 8'h08;
        wr(TS, 8'h60);
        wait_idle();
        rd(CS, v);
        `CHK("switched source status", 8'hB1, v)
        wr(TS, 8'h00);
        wait_idle();
        `CHK("free running no trigger", 1'b0, conv_active_o)
        d0 = dones;
        wr(CS, 8'hF1);
        for (k = 0; k < 400 && 8'(dones - d0) < 8'd3; k++)
            @(posedge clock_i);
        `CHK("free running restarts", 8'd3, 8'(dones - d0))
        wr(CS, 8'h00);
        final_report();
    end
endmodule : acc_conversion_control_tb

`default_nettype wire
